// file: hw/tdr_conv.sv
// Result arithmetic for one channel conversion: diode difference or divider ratio.
module tdr_conv
    import tdr_pkg::*;
#(
    parameter logic [15:0] LOCAL_ZERO = 16'h0000
)
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Request.
    input wire logic start,
    input wire logic is_local,
    input wire logic [15:0] samp0,
    input wire logic [15:0] samp1,
    input wire logic [7:0] offset,
    // Answer.
    output logic done,
    output tdr_temp_t result
);

    logic busy_r;
    logic [2:0] cnt_r;
    logic [16:0] rem_r;
    logic [15:0] den_r;
    logic [7:0] q_r;
    logic [16:0] rem_sh;
    logic [16:0] rem_nxt;
    logic [7:0] q_nxt;
    logic signed [17:0] diode;

    // Adds the signed offset to a ratio and clips into 0..255.
    function automatic logic [7:0] therm_finish(input logic [7:0] q, input logic [7:0] ofs);
        logic signed [9:0] s;
        s = $signed({2'b00, q}) + $signed({{2{ofs[7]}}, ofs});
        if (s < 0)
            return 8'h00;
        else if (s > 10'sd255)
            return 8'hff;
        else
            return s[7:0];
    endfunction

    always_comb
    begin
        rem_sh = {rem_r[15:0], 1'b0};
        if (rem_sh >= {1'b0, den_r})
        begin
            rem_nxt = rem_sh - {1'b0, den_r};
            q_nxt = {q_r[6:0], 1'b1};
        end
        else
        begin
            rem_nxt = rem_sh;
            q_nxt = {q_r[6:0], 1'b0};
        end
        diode = $signed({2'b00, samp1}) - $signed({2'b00, samp0})
            - $signed({2'b00, LOCAL_ZERO}); // RL14
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            busy_r <= 1'b0;
            cnt_r <= 3'h0;
            rem_r <= 17'h00000;
            den_r <= 16'h0000;
            q_r <= 8'h00;
            done <= 1'b0;
            result <= '0;
        end
        else
        begin
            done <= 1'b0;
            if (start && is_local)
            begin
                done <= 1'b1;
                if (diode < 0)
                    result <= '0; // RL8
                else if (diode > 18'sd2047)
                    result <= '{hi: 8'hff, lo: {{FRAC_BITS{1'b1}}, {FRAC_LSB{1'b0}}}};
                else
                    result <= '{hi: diode[10:3], lo: {diode[2:0], {FRAC_LSB{1'b0}}}}; // RL9
            end
            else if (start)
            begin
                // Reference in samp0, thermistor node in samp1; the ratio is the
                // series resistor share of the reference.
                if (samp0 <= samp1)
                begin
                    done <= 1'b1;
                    result <= '{hi: therm_finish(8'h00, offset), lo: 8'h00}; // RL12
                end
                else if (samp1 == 16'h0000)
                begin
                    done <= 1'b1;
                    result <= '{hi: therm_finish(8'hff, offset), lo: 8'h00};
                end
                else
                begin
                    busy_r <= 1'b1; // RL13
                    cnt_r <= 3'h0;
                    rem_r <= {1'b0, samp0 - samp1};
                    den_r <= samp0;
                    q_r <= 8'h00;
                end
            end
            else if (busy_r)
            begin
                rem_r <= rem_nxt;
                q_r <= q_nxt;
                cnt_r <= cnt_r + 3'h1;
                if (cnt_r == 3'h7)
                begin
                    busy_r <= 1'b0;
                    done <= 1'b1;
                    result <= '{hi: therm_finish(q_nxt, offset), lo: 8'h00}; // RL15
                end
            end
        end
    end

    a_frac_low: assert property (@(posedge clk) disable iff (rst) // RL9
        done |-> result.lo[FRAC_LSB-1:0] == '0)
        else $error("Low byte carries bits below the fraction.");

    a_local_negative: assert property (@(posedge clk) disable iff (rst) // RL8
        start && is_local && samp1 < samp0 |=> done && result == '0)
        else $error("Negative local reading not clipped to zero.");

    a_offset_clip: assert property (@(posedge clk) disable iff (rst) // RL12
        start && !is_local && samp0 <= samp1 && offset[7] |=> done && result == '0)
        else $error("Negative corrected thermistor reading not stored as zero.");

    a_divide_time: assert property (@(posedge clk) disable iff (rst) // RL15
        start && !is_local && samp0 > samp1 && samp1 != 16'h0000
        |-> ##1 !done [*8] ##1 done && result.lo == 8'h00)
        else $error("Thermistor ratio not ready nine cycles after start.");

endmodule

// file: hw/tdr_pkg.sv
// Shared constants, types and state encodings for the dual temperature readout.
package tdr_pkg;

    // Clock and timebase.
    localparam int CLK_PERIOD_NS = 5;
    localparam int TICK_NS = 1000;
    localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONV_WINDOW_MS = 120;
    localparam int CONV_WINDOW_TICKS = CONV_WINDOW_MS * 1000000 / TICK_NS;

    // Register offsets, reset values and field layout.
    localparam logic [7:0] REG_TEMP_A_HI = 8'h00;
    localparam logic [7:0] REG_TEMP_B_HI = 8'h01;
    localparam logic [7:0] REG_THERM_OFS = 8'h17;
    localparam logic [7:0] REG_LOCAL_FRAC = 8'h1f;
    localparam logic [7:0] TEMP_RST = 8'h00;
    localparam logic [7:0] THERM_OFS_RST = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    localparam int FRAC_BITS = 3;
    localparam int FRAC_LSB = 8 - FRAC_BITS;

    // Selectable target addresses; the values are arbitrary.
    localparam int NUM_TARGET_ADDR = 9;
    localparam logic [6:0] TARGET_ADDR [0:8] = '{
        7'h18, 7'h19, 7'h1a, 7'h29, 7'h2a, 7'h2b, 7'h4c, 7'h4d, 7'h4e
    };

    // Serial line: the open-drain pin only ever pulls low.
    localparam logic SDA_PULL = 1'b0;

    typedef struct packed {
        logic [7:0] hi;
        logic [7:0] lo;
    } tdr_temp_t;

    typedef struct packed {
        logic chan;
        logic meas_hi;
    } tdr_adc_sel_t;

    typedef enum {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_CMD,
        ST_CMD_ACK,
        ST_WDATA,
        ST_WDATA_ACK,
        ST_RDATA,
        ST_RDATA_ACK
    } tdr_bus_st_t;

endpackage

// file: hw/tdr_top.sv
// Dual temperature readout: serial register port, conversion sequencer, result registers.
// Functional notes
// RL1: All state is visible as byte-wide registers through the two-wire port.
// RL2: Only write, read, send and receive byte transfers reach the registers.
// RL3: The device answers one of nine strap-selected target addresses.
// RL4: Receive byte returns the register last chosen by a command byte.
// RL5: Multi-master hosts should avoid short transfers; command byte can change.
// RL6: Channel temperatures sit at 00h and 01h, unsigned, one degree per bit.
// RL7: Every data byte is shifted out most significant bit first.
// RL8: Readings below zero store zero in high and low byte.
// RL9: Local low byte holds three fraction bits on top, lower bits zero.
// RL10: Each channel integrates for a nominal 120 ms before its result lands.
// RL11: After start, both channels convert in turn, sensor attached or not.
// RL12: A negative offset at 17h driving a result below zero stores zero.
// RL13: Thermistor channels measure reference and node, then add the offset.
// RL14: Local channel samples the diode at low then high bias current.
// RL15: Thermistor value is series resistor voltage as a share of reference.
// RL16: Host does not acknowledge the single read byte and then stops.
// RL17: High and low bytes of a channel update together at conversion end.
module tdr_top
    import tdr_pkg::*;
#(
    parameter int WINDOW_TICKS = CONV_WINDOW_TICKS,
    parameter logic [15:0] LOCAL_ZERO = 16'h0000
)
(
    // Clock and reset.
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    // Two-wire serial port.
    input wire logic SCL,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE_N,
    // Straps and run control.
    input wire logic [3:0] ADDR_SEL,
    input wire logic CONV_RUN,
    input wire logic CHA_LOCAL,
    // Measurement front end.
    input wire logic [15:0] ADC_DATA,
    output tdr_adc_sel_t ADC_SEL
);

    localparam int HALF_TICKS = WINDOW_TICKS / 2;

    logic [7:0] sync1_r;
    logic [7:0] sync2_r;
    logic scl_d_r;
    logic sda_d_r;
    logic scl_s;
    logic sda_s;
    logic run_s;
    logic cha_local_s;
    logic [3:0] addr_sel_s;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic [6:0] my_addr;

    tdr_bus_st_t st_r;
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic rw_r;
    logic drive_low_r;
    logic [7:0] cmd_r;
    logic [7:0] tx_r;
    logic wr_strobe_r;
    logic [7:0] wr_data_r;
    logic [7:0] rd_byte;

    logic [7:0] ofs_r;
    logic [7:0] temp_a_r;
    logic [7:0] temp_b_r;
    logic [7:0] frac_r;

    logic [7:0] tick_cnt_r;
    logic tick;
    logic [23:0] win_cnt_r;
    logic win_end;
    logic phase_r;
    logic chan_r;
    logic [15:0] samp0_r;
    logic [15:0] samp1_r;
    logic conv_start_r;
    logic conv_chan_r;
    logic conv_local_r;
    logic cdone;
    tdr_temp_t cres;
    logic last_chan_r;

    // Maps a strap code to its target address; codes above eight fall back to the first.
    function automatic logic [6:0] addr_lookup(input logic [3:0] sel);
        if (sel < 4'(NUM_TARGET_ADDR))
            return TARGET_ADDR[sel];
        else
            return TARGET_ADDR[0];
    endfunction

    // Register read decode, shared by the transmitter and its checks.
    function automatic logic [7:0] reg_read(input logic [7:0] a, input logic [7:0] ta,
        input logic [7:0] tb, input logic [7:0] fr, input logic [7:0] ofs);
        if (a == REG_TEMP_A_HI)
            return ta;
        else if (a == REG_TEMP_B_HI)
            return tb;
        else if (a == REG_LOCAL_FRAC)
            return fr;
        else if (a == REG_THERM_OFS)
            return ofs;
        else
            return UNMAPPED_READ;
    endfunction

    // Every input except ADC_DATA, CLK_SYS and SYS_RST passes two flops; only the second stage and its delayed copy are read.
    always_ff @(posedge CLK_SYS or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            sync1_r <= 8'hc0;
            sync2_r <= 8'hc0;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end
        else
        begin
            sync1_r <= {SCL, SDA_IN, CONV_RUN, CHA_LOCAL, ADDR_SEL};
            sync2_r <= sync1_r;
            scl_d_r <= sync2_r[7];
            sda_d_r <= sync2_r[6];
        end
    end

    assign scl_s = sync2_r[7];
    assign sda_s = sync2_r[6];
    assign run_s = sync2_r[5];
    assign cha_local_s = sync2_r[4];
    assign addr_sel_s = sync2_r[3:0];
    assign scl_rise = scl_s && !scl_d_r;
    assign scl_fall = !scl_s && scl_d_r;
    assign bus_start = scl_s && scl_d_r && !sda_s && sda_d_r;
    assign bus_stop = scl_s && scl_d_r && sda_s && !sda_d_r;
    assign my_addr = addr_lookup(addr_sel_s); // RL3
    assign rd_byte = reg_read(cmd_r, temp_a_r, temp_b_r, frac_r, ofs_r); // RL4

    assign SDA_OUT = SDA_PULL;
    assign SDA_OE_N = !drive_low_r;

    // Byte-protocol target. Bits are taken on SCL rising and driven after SCL falling.
    always_ff @(posedge CLK_SYS or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            st_r <= ST_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
            rw_r <= 1'b0;
            drive_low_r <= 1'b0;
            cmd_r <= REG_TEMP_A_HI;
            tx_r <= 8'h00;
            wr_strobe_r <= 1'b0;
            wr_data_r <= 8'h00;
        end
        else
        begin
            wr_strobe_r <= 1'b0;
            if (bus_start)
            begin
                st_r <= ST_ADDR;
                bit_cnt_r <= 4'h0;
                drive_low_r <= 1'b0;
            end
            else if (bus_stop)
            begin
                st_r <= ST_IDLE;
                drive_low_r <= 1'b0;
            end
            else if (scl_rise && st_r != ST_IDLE)
            begin
                shift_r <= {shift_r[6:0], sda_s};
                bit_cnt_r <= bit_cnt_r + 4'h1;
            end
            else if (scl_fall)
            begin
                case (st_r)
                    ST_ADDR:
                        if (bit_cnt_r == 4'h8)
                        begin
                            if (shift_r[7:1] == my_addr)
                            begin
                                st_r <= ST_ADDR_ACK; // RL3
                                rw_r <= shift_r[0];
                                drive_low_r <= 1'b1;
                            end
                            else
                                st_r <= ST_IDLE;
                        end
                    ST_ADDR_ACK:
                    begin
                        bit_cnt_r <= 4'h0;
                        if (rw_r)
                        begin
                            // Read byte and receive byte both answer from the stored command.
                            tx_r <= rd_byte; // RL4
                            drive_low_r <= !rd_byte[7]; // RL7
                            st_r <= ST_RDATA;
                        end
                        else
                        begin
                            drive_low_r <= 1'b0;
                            st_r <= ST_CMD;
                        end
                    end
                    ST_CMD:
                        if (bit_cnt_r == 4'h8)
                        begin
                            cmd_r <= shift_r; // RL2
                            drive_low_r <= 1'b1;
                            st_r <= ST_CMD_ACK;
                        end
                    ST_CMD_ACK:
                    begin
                        drive_low_r <= 1'b0;
                        bit_cnt_r <= 4'h0;
                        st_r <= ST_WDATA;
                    end
                    ST_WDATA:
                        if (bit_cnt_r == 4'h8)
                        begin
                            wr_strobe_r <= 1'b1; // RL2
                            wr_data_r <= shift_r;
                            drive_low_r <= 1'b1;
                            st_r <= ST_WDATA_ACK;
                        end
                    ST_WDATA_ACK:
                    begin
                        // One data byte per write; further bytes go unanswered.
                        drive_low_r <= 1'b0;
                        st_r <= ST_IDLE;
                    end
                    ST_RDATA:
                        if (bit_cnt_r == 4'h8)
                        begin
                            drive_low_r <= 1'b0;
                            st_r <= ST_RDATA_ACK;
                        end
                        else
                            drive_low_r <= !tx_r[3'(4'h7 - bit_cnt_r)]; // RL7
                    ST_RDATA_ACK:
                        st_r <= ST_IDLE; // RL16
                    default:
                        st_r <= ST_IDLE;
                endcase
            end
        end
    end

    // Only the offset register takes writes; writes elsewhere are dropped.
    always_ff @(posedge CLK_SYS or posedge SYS_RST)
    begin
        if (SYS_RST)
            ofs_r <= THERM_OFS_RST;
        else if (wr_strobe_r && cmd_r == REG_THERM_OFS)
            ofs_r <= wr_data_r; // RL1
    end

    // Timebase of one microsecond per tick.
    always_ff @(posedge CLK_SYS or posedge SYS_RST)
    begin
        if (SYS_RST)
            tick_cnt_r <= 8'h00;
        else if (tick)
            tick_cnt_r <= 8'h00;
        else
            tick_cnt_r <= tick_cnt_r + 8'h01;
    end

    assign tick = tick_cnt_r == 8'(TICK_CYCLES - 1);
    assign win_end = tick && win_cnt_r == 24'(HALF_TICKS - 1);

    // Each channel window has two halves: low bias or reference first, then the other.
    always_ff @(posedge CLK_SYS or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            win_cnt_r <= 24'h000000;
            phase_r <= 1'b0;
            chan_r <= 1'b0;
            samp0_r <= 16'h0000;
            samp1_r <= 16'h0000;
            conv_start_r <= 1'b0;
            conv_chan_r <= 1'b0;
            conv_local_r <= 1'b0;
        end
        else
        begin
            conv_start_r <= 1'b0;
            if (!run_s)
            begin
                win_cnt_r <= 24'h000000;
                phase_r <= 1'b0;
            end
            else if (win_end)
            begin
                win_cnt_r <= 24'h000000;
                phase_r <= !phase_r;
                if (!phase_r)
                    samp0_r <= ADC_DATA; // RL14
                else
                begin
                    samp1_r <= ADC_DATA; // RL13
                    conv_start_r <= 1'b1; // RL10
                    conv_chan_r <= chan_r;
                    conv_local_r <= !chan_r && cha_local_s;
                    chan_r <= !chan_r; // RL11
                end
            end
            else if (tick)
                win_cnt_r <= win_cnt_r + 24'h000001;
        end
    end

    assign ADC_SEL = '{chan: chan_r, meas_hi: phase_r};

    tdr_conv #(
        .LOCAL_ZERO(LOCAL_ZERO)
    ) u_conv (
        .clk(CLK_SYS),
        .rst(SYS_RST),
        .start(conv_start_r),
        .is_local(conv_local_r),
        .samp0(samp0_r),
        .samp1(samp1_r),
        .offset(ofs_r),
        .done(cdone),
        .result(cres)
    );

    // Both bytes of a result land in one edge so a reader never sees a torn pair.
    always_ff @(posedge CLK_SYS or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            temp_a_r <= TEMP_RST;
            temp_b_r <= TEMP_RST;
            frac_r <= TEMP_RST;
        end
        else if (cdone && !conv_chan_r)
        begin
            temp_a_r <= cres.hi; // RL6
            frac_r <= cres.lo; // RL17
        end
        else if (cdone)
            temp_b_r <= cres.hi; // RL6
    end

    always_ff @(posedge CLK_SYS or posedge SYS_RST)
    begin
        if (SYS_RST)
            last_chan_r <= 1'b1;
        else if (conv_start_r)
            last_chan_r <= conv_chan_r;
    end

    sequence s_addr_match;
        st_r == ST_ADDR && scl_fall && !bus_start && !bus_stop && bit_cnt_r == 4'h8
            && shift_r[7:1] == my_addr;
    endsequence

    sequence s_read_launch;
        st_r == ST_ADDR_ACK && scl_fall && !bus_start && !bus_stop && rw_r;
    endsequence

    a_addr_ack: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RL3
        s_addr_match |=> st_r == ST_ADDR_ACK && !SDA_OE_N)
        else $error("Matching target address not acknowledged.");

    a_msb_first: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RL7
        s_read_launch |=> st_r == ST_RDATA && SDA_OE_N == tx_r[7])
        else $error("First data bit driven is not the top bit.");

    a_recv_cmd: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RL4
        s_read_launch |=> tx_r == reg_read($past(cmd_r), $past(temp_a_r), $past(temp_b_r),
            $past(frac_r), $past(ofs_r)))
        else $error("Returned byte is not the register chosen by the command.");

    a_ofs_write: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RL2
        $changed(ofs_r) |-> $past(wr_strobe_r) && $past(cmd_r) == REG_THERM_OFS)
        else $error("Offset register changed without a write to it.");

    a_pair_update: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RL17
        $changed(frac_r) || $changed(temp_a_r) |-> $past(cdone) && !$past(conv_chan_r))
        else $error("Channel bytes changed outside a conversion end.");

    a_window_end: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RL10
        conv_start_r |-> $past(win_cnt_r) == 24'(HALF_TICKS - 1) && $past(tick) && !phase_r)
        else $error("Conversion launched before the window closed.");

    a_chan_alternate: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RL11
        conv_start_r |-> conv_chan_r != last_chan_r)
        else $error("Channels not converted in turn.");

endmodule

// file: tb/tb_dual_temp_readout_serial_regs.sv
// Self-checking bench: serial register access and conversion results.
module tb_dual_temp_readout_serial_regs
    import tdr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WT = 20;
    logic CLK_SYS = 1'b0;
    logic SYS_RST = 1'b1;
    logic [3:0] ADDR_SEL = 4'h0;
    logic CONV_RUN = 1'b0;
    logic CHA_LOCAL = 1'b1;
    logic [15:0] ADC_DATA = 16'h0000;
    logic SDA_OUT, SDA_OE_N, scl, sda_rel;
    tdr_adc_sel_t ADC_SEL;
    logic [15:0] a0 = 16'h0000, a1 = 16'h0000, b0 = 16'h0001, b1 = 16'h0000;
    logic [6:0] addr;
    int n_mismatch = 0;
    int num_checks = 0;
    int seed = 32'h3087246a;
    // Open drain: the pull-up wins unless someone pulls low.
    wire logic sda = sda_rel & (SDA_OE_N | SDA_OUT);
    tdr_top #(.WINDOW_TICKS(WT)) dut (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .SCL(scl),
        .SDA_IN(sda), .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N), .ADDR_SEL(ADDR_SEL),
        .CONV_RUN(CONV_RUN), .CHA_LOCAL(CHA_LOCAL), .ADC_DATA(ADC_DATA), .ADC_SEL(ADC_SEL));
    tdr_host host (.scl(scl), .sda_rel(sda_rel), .sda(sda));
    always #2.5 CLK_SYS = ~CLK_SYS;
    always @(negedge CLK_SYS)
        ADC_DATA <= ADC_SEL.chan ? (ADC_SEL.meas_hi ? b1 : b0) : (ADC_SEL.meas_hi ? a1 : a0);
    function automatic logic [15:0] local_exp(logic [15:0] lo, logic [15:0] hi);
        int e;
        e = int'(hi) - int'(lo);
        e = (e < 0) ? 0 : (e > 2047) ? 2047 : e;
        return {e[10:3], e[2:0], 5'h00};
    endfunction
    function automatic logic [7:0] therm_exp(logic [15:0] rf, logic [15:0] nd, logic [7:0] o);
        int r;
        r = (nd >= rf) ? 0 : (nd == 0) ? 255 : (256 * (int'(rf) - int'(nd))) / int'(rf);
        r = r + int'($signed(o));
        return (r < 0) ? 8'h00 : (r > 255) ? 8'hff : r[7:0];
    endfunction
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic reg_rd(input logic [7:0] c, input logic [7:0] exp);
        logic [7:0] q;
        logic ok;
        host.run(2, addr, c, 8'h00, q, ok);
        check8({7'h00, ok}, 8'h01);
        check8(q, exp);
    endtask
    task automatic conclude();
        $display("checks %0d, mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        repeat (90000) @(posedge CLK_SYS);
        n_mismatch++;
        conclude();
    end
    initial
    begin
        logic [7:0] q, ofs;
        logic [15:0] ea;
        logic ok;
        int r;
        repeat (6) @(negedge CLK_SYS);
        SYS_RST <= 1'b0;
        repeat (4) @(negedge CLK_SYS);
        addr = TARGET_ADDR[0];
        reg_rd(REG_TEMP_A_HI, TEMP_RST);
        reg_rd(REG_LOCAL_FRAC, TEMP_RST);
        reg_rd(REG_THERM_OFS, THERM_OFS_RST);
        host.run(0, addr ^ 7'h40, REG_THERM_OFS, 8'h55, q, ok);
        check8({7'h00, ok}, 8'h00);
        host.run(0, addr, REG_TEMP_A_HI, 8'h5a, q, ok);
        reg_rd(REG_TEMP_A_HI, TEMP_RST);
        reg_rd(8'h05, UNMAPPED_READ);
        // Every strap code, including the out-of-range ones that fall back to code 0.
        for (int s = 0; s < 16; s++)
        begin
            @(negedge CLK_SYS);
            ADDR_SEL <= s[3:0];
            addr = TARGET_ADDR[(s > 8) ? 0 : s];
            ofs = 8'($random(seed));
            repeat (4) @(negedge CLK_SYS);
            host.run(0, addr, REG_THERM_OFS, ofs, q, ok);
            check8({7'h00, ok}, 8'h01);
            reg_rd(REG_THERM_OFS, ofs);
        end
        CONV_RUN <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            r = $random(seed);
            a0 = {1'b0, r[14:0]} + 16'h1000;
            a1 = (i == 2) ? a0 - 16'h0010 : a0 + 16'(32'(r[27:16]) - 512);
            b0 = 16'($random(seed)) | 16'h0001;
            b1 = (i == 0) ? b0 : (i == 3) ? 16'h0000 : 16'($random(seed));
            ofs = (i == 1) ? 8'h80 : 8'($random(seed));
            @(negedge CLK_SYS);
            CHA_LOCAL <= (i != 1);
            host.run(0, addr, REG_THERM_OFS, ofs, q, ok);
            repeat (3 * WT * TICK_CYCLES) @(negedge CLK_SYS);
            ea = (i != 1) ? local_exp(a0, a1) : {therm_exp(a0, a1, ofs), 8'h00};
            reg_rd(REG_TEMP_A_HI, ea[15:8]);
            reg_rd(REG_LOCAL_FRAC, ea[7:0]);
            reg_rd(REG_TEMP_B_HI, therm_exp(b0, b1, ofs));
            host.run(1, addr, REG_TEMP_A_HI, 8'h00, q, ok);
            host.run(3, addr, 8'h00, 8'h00, q, ok);
            check8(q, ea[15:8]);
            reg_rd(REG_THERM_OFS, ofs);
            host.run(3, addr, 8'h00, 8'h00, q, ok);
            check8(q, ofs);
        end
        conclude();
    end
endmodule

// file: tb/tdr_host.sv
// Behavioural two-wire host that issues the four byte transfers.
module tdr_host
(
    // Serial wires.
    output logic scl,
    output logic sda_rel,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end
    task automatic start();
        sda_rel = 1'b1;
        // Give the target time to release its acknowledge before SCL rises.
        #30 scl = 1'b1;
        #24 sda_rel = 1'b0;
        #24 scl = 1'b0;
        #12;
    endtask
    task automatic stop();
        sda_rel = 1'b0;
        #12 scl = 1'b1;
        #24 sda_rel = 1'b1;
        #24;
    endtask
    // SCL only moves inside frames; data changes well after the low phase begins.
    task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
        output logic ack);
        for (int i = 7; i >= 0; i--)
        begin
            #6 sda_rel = tx[i];
            #18 scl = 1'b1;
            #24 rx[i] = sda;
            scl = 1'b0;
        end
        #6 sda_rel = ack_in;
        #18 scl = 1'b1;
        #24 ack = ~sda;
        scl = 1'b0;
    endtask
    // Kind 0 write, 1 send, 2 read, 3 receive byte.
    // Single master here, so the short transfers are safe to use.
    task automatic run(input int kind, input logic [6:0] a, input logic [7:0] c,
        input logic [7:0] d, output logic [7:0] q, output logic ok);
        logic k;
        start();
        xfer({a, kind == 3}, 1'b1, q, k);
        ok = k;
        if (kind != 3)
        begin
            xfer(c, 1'b1, q, k);
            ok &= k;
        end
        if (kind == 0)
        begin
            xfer(d, 1'b1, q, k);
            ok &= k;
        end
        if (kind == 2)
        begin
            start();
            xfer({a, 1'b1}, 1'b1, q, k);
            ok &= k;
        end
        if (kind >= 2)
            xfer(8'hff, 1'b1, q, k);
        stop();
    endtask
endmodule
